// ==== pwcs_pkg.sv ====
package pwcs_pkg;
  localparam int PWCS_AW = 32;
  localparam logic [31:0] PWCS_VGA_LO = 32'h000A_0000;
  localparam logic [31:0] PWCS_VGA_HI = 32'h000B_FFFF;
  localparam logic [31:0] PWCS_BIOS_LO = 32'h000E_0000;
  localparam logic [31:0] PWCS_LOW_TOP = 32'h0008_0000;
  localparam logic [31:0] PWCS_ONE_MB = 32'h0010_0000;
  localparam int PWCS_TOM_SHIFT = 21;
  localparam int PWCS_HOLE_SHIFT = 16;
  localparam int PWCS_TOM_W = 8;
  localparam int PWCS_HOLE_W = 16;
  localparam int PWCS_LOW_W = 8;
  localparam int PWCS_LOW_SHIFT = 16;
  localparam int PWCS_BIOS_N = 3;
  localparam int PWCS_BIOS_SHIFT = 15;
  localparam logic [1:0] PWCS_ATTR_RW = 2'h3;
  localparam int PWCS_MASK_LSB = 20;
endpackage

// ==== pwcs_window0_decode.sv ====
`timescale 1ns/1ps
// Function
// [R1] Never select inside the VGA frame hole
// [R2] Per-region read/write attributes gate select (code: one low_region_attr pair shared by all low regions, none from 1MB up)
// [R3] Top of memory bounds select, 2MB steps
// [R4] Programmable 64KB-granular hole suppresses select
// [R5] Three BIOS enables gate BIOS portions
// [R6] Control gates decoder, picks low regions
// [R7] Only window 0 may use select
// [R8] Asserted select gives hit and DEVSEL
// [R9] Software sizes window over select region
// [R10] Scatter-gather bit still picks translation
// [R11] Software matches mask to select size
// [R12] Select enable overrides ordinary window enable
// [R13] Scatter-gather set means table lookup
// [R14] Path off falls back to base compare
module pwcs_window0_decode
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic addr_valid,
  input wire logic [pwcs_pkg::PWCS_AW-1:0] pci_addr,
  input wire logic pci_write,
  input wire logic [pwcs_pkg::PWCS_TOM_W-1:0] select_top_of_memory,
  input wire logic [pwcs_pkg::PWCS_HOLE_W-1:0] select_hole_top,
  input wire logic [pwcs_pkg::PWCS_HOLE_W-1:0] select_hole_bottom,
  input wire logic [1:0] bios_region_enable_1,
  input wire logic [1:0] bios_region_enable_2,
  input wire logic [1:0] bios_region_enable_3,
  input wire logic select_decode_enable,
  input wire logic [pwcs_pkg::PWCS_LOW_W-1:0] select_decode_control,
  input wire logic [1:0] low_region_attr,
  input wire logic [11:0] window0_base_reg,
  input wire logic [11:0] window0_size_mask,
  input wire logic window0_enable,
  input wire logic sg_translate_bit,
  input wire logic window0_select_path_enable,
  output logic mem_select_b,
  output logic window0_hit,
  output logic devsel_b,
  output logic sg_lookup,
  output logic direct_map
);
  import pwcs_pkg::*;

  logic [PWCS_AW-1:0] a_r;
  logic wr_r;
  logic vld_r;
  logic hit_r;
  logic sg_r;
  logic cs_r;

  // Address is registered once so all decode terms see one stable cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      a_r <= '0;
      wr_r <= 1'b0;
      vld_r <= 1'b0;
    end
    else
    begin
      a_r <= pci_addr;
      wr_r <= pci_write;
      vld_r <= addr_valid;
    end
  end

  wire [PWCS_AW-1:0] tom_addr =
    {{(PWCS_AW-PWCS_TOM_W-PWCS_TOM_SHIFT){1'b0}}, select_top_of_memory,
     {PWCS_TOM_SHIFT{1'b0}}};
  wire [PWCS_AW-1:0] hole_lo =
    {select_hole_bottom, {PWCS_HOLE_SHIFT{1'b0}}};
  wire [PWCS_AW-1:0] hole_hi =
    {select_hole_top, {PWCS_HOLE_SHIFT{1'b0}}};
  wire in_vga = (a_r >= PWCS_VGA_LO) && (a_r <= PWCS_VGA_HI); // [R1]
  // Zero top means only the first megabyte is covered
  wire below_tom = (a_r < tom_addr) || (a_r < PWCS_ONE_MB); // [R3]
  wire in_hole = (a_r >= hole_lo) && (a_r < hole_hi); // [R4]
  wire is_low = a_r < PWCS_LOW_TOP;
  wire [2:0] low_idx = a_r[PWCS_LOW_SHIFT+2:PWCS_LOW_SHIFT];
  wire low_on = select_decode_control[low_idx]; // [R6]
  wire attr_ok_low = wr_r ? low_region_attr[1] : low_region_attr[0]; // [R2]
  wire is_bios = (a_r >= PWCS_BIOS_LO) && (a_r < PWCS_ONE_MB);
  wire [1:0] bios_idx = a_r[PWCS_BIOS_SHIFT+1:PWCS_BIOS_SHIFT];
  wire [1:0] bios_attr =
    (bios_idx == 2'h0) ? bios_region_enable_1 :
    (bios_idx == 2'h1) ? bios_region_enable_2 :
    bios_region_enable_3; // [R5]
  wire bios_ok = wr_r ? bios_attr[1] : bios_attr[0]; // [R2] [R5]
  wire mid_ok = !is_low && !is_bios && (a_r >= PWCS_ONE_MB);
  // Addresses between 512KB and the BIOS area outside VGA are not decoded
  wire cs_raw = select_decode_enable && vld_r && !in_vga && below_tom &&
    !in_hole && ((is_low && low_on && attr_ok_low) || (is_bios && bios_ok) ||
    mid_ok); // [R1] [R6]

  wire [11:0] mask_n = ~window0_size_mask;
  wire base_match =
    ((a_r[PWCS_AW-1:PWCS_MASK_LSB] ^ window0_base_reg) & mask_n) == 12'h000;
  // Select path enable wins over the ordinary window enable
  wire w0_hit = window0_select_path_enable ? cs_raw :
    (window0_enable && vld_r && base_match); // [R7] [R12] [R14]

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hit_r <= 1'b0;
      sg_r <= 1'b0;
      cs_r <= 1'b0;
    end
    else
    begin
      hit_r <= w0_hit; // [R8]
      sg_r <= w0_hit && sg_translate_bit; // [R10] [R13]
      cs_r <= cs_raw;
    end
  end

  assign mem_select_b = !cs_r;
  assign window0_hit = hit_r;
  assign devsel_b = !hit_r; // [R8]
  assign sg_lookup = sg_r;
  assign direct_map = hit_r && !sg_r; // [R13]

  // Checker-only terms; the answer always shows one edge after these
  wire in_gap = (a_r >= PWCS_LOW_TOP) && (a_r < PWCS_VGA_LO);
  wire in_opt = (a_r > PWCS_VGA_HI) && (a_r < PWCS_BIOS_LO);
  wire cmp_hit = window0_enable && vld_r && base_match;

  sequence s_take;
    select_decode_enable && vld_r;
  endsequence

  sequence s_idle;
    !vld_r;
  endsequence

  sequence s_path_sel;
    window0_select_path_enable && cs_raw;
  endsequence

  sequence s_path_nosel;
    window0_select_path_enable && !cs_raw;
  endsequence

  sequence s_cmp_only;
    !window0_select_path_enable && cmp_hit;
  endsequence

  sequence s_sg_hit;
    w0_hit && sg_translate_bit;
  endsequence

  sequence s_dm_hit;
    w0_hit && !sg_translate_bit;
  endsequence

  sequence s_answer;
    window0_hit && !devsel_b && !mem_select_b;
  endsequence

  AST_VGA_NEVER: assert property (@(posedge clock) // [R1]
    disable iff (!rst_b) $past(in_vga) |-> mem_select_b)
    else $error("select asserted in VGA hole");

  AST_HOLE: assert property (@(posedge clock) // [R4]
    disable iff (!rst_b) $past(in_hole) |-> mem_select_b)
    else $error("select asserted in hole");

  AST_TOM: assert property (@(posedge clock) // [R3]
    disable iff (!rst_b) $past(!below_tom) |-> mem_select_b)
    else $error("select above top of memory");

  AST_CTRL_OFF: assert property (@(posedge clock) // [R6]
    disable iff (!rst_b) $past(!select_decode_enable) |-> mem_select_b)
    else $error("select while decoder disabled");

  AST_DEVSEL: assert property (@(posedge clock) // [R8]
    disable iff (!rst_b) $past(window0_select_path_enable && cs_raw) |->
    !devsel_b && !mem_select_b)
    else $error("select without DEVSEL");

  AST_PRIO: assert property (@(posedge clock) // [R12]
    disable iff (!rst_b) $past(window0_select_path_enable && !cs_raw) |->
    devsel_b)
    else $error("window enable overrode select path");

  AST_FALLBACK: assert property (@(posedge clock) // [R14]
    disable iff (!rst_b) $past(!window0_select_path_enable) |->
    (window0_hit == $past(window0_enable && vld_r && base_match)))
    else $error("fallback compare wrong");

  AST_SG: assert property (@(posedge clock) // [R10]
    disable iff (!rst_b) window0_hit |->
    (sg_lookup == $past(sg_translate_bit)) && (direct_map == !sg_lookup))
    else $error("translation choice wrong");

  AST_BIOS: assert property (@(posedge clock) // [R5]
    disable iff (!rst_b) $past(is_bios && !bios_ok && !mid_ok) |->
    mem_select_b)
    else $error("disabled BIOS portion selected");

  AST_IDLE: assert property (@(posedge clock) // [R8]
    disable iff (!rst_b) s_idle |=> devsel_b && mem_select_b)
    else $error("answer without address phase");

  AST_PATH_ANSWER: assert property (@(posedge clock) // [R8]
    disable iff (!rst_b) s_path_sel |=> s_answer)
    else $error("select path hit not answered");

  AST_PATH_MISS: assert property (@(posedge clock) // [R7]
    disable iff (!rst_b) s_path_nosel |=> !window0_hit && mem_select_b)
    else $error("select path hit without select");

  AST_PRIO_BASE: assert property (@(posedge clock) // [R12]
    disable iff (!rst_b)
    window0_select_path_enable && cmp_hit && !cs_raw |=> devsel_b)
    else $error("base compare used while select path on");

  AST_CMP_HIT: assert property (@(posedge clock) // [R14]
    disable iff (!rst_b) s_cmp_only |=> window0_hit && !devsel_b)
    else $error("base compare hit lost");

  AST_CMP_IGNORE_CS: assert property (@(posedge clock) // [R14]
    disable iff (!rst_b)
    !window0_select_path_enable && !cmp_hit && cs_raw |=> !window0_hit)
    else $error("select used while path off");

  AST_SG_PATH: assert property (@(posedge clock) // [R13]
    disable iff (!rst_b) s_sg_hit |=> sg_lookup && !direct_map)
    else $error("table lookup not chosen");

  AST_DM_PATH: assert property (@(posedge clock) // [R13]
    disable iff (!rst_b) s_dm_hit |=> direct_map && !sg_lookup)
    else $error("direct mapping not chosen");

  AST_NO_XLATE: assert property (@(posedge clock) // [R10]
    disable iff (!rst_b) !window0_hit |-> !sg_lookup && !direct_map)
    else $error("translation without hit");

  AST_GAP: assert property (@(posedge clock) // [R6]
    disable iff (!rst_b) in_gap |=> mem_select_b)
    else $error("select above low regions");

  AST_OPT_ROM: assert property (@(posedge clock) // [R2]
    disable iff (!rst_b) in_opt |=> mem_select_b)
    else $error("select below BIOS area");

  AST_LOW_OFF: assert property (@(posedge clock) // [R6]
    disable iff (!rst_b) is_low && !low_on |=> mem_select_b)
    else $error("disabled low region selected");

  AST_LOW_ATTR: assert property (@(posedge clock) // [R2]
    disable iff (!rst_b) is_low && !attr_ok_low |=> mem_select_b)
    else $error("low region attribute ignored");

  AST_LOW_ON: assert property (@(posedge clock) // [R6]
    disable iff (!rst_b)
    s_take ##0 (is_low && low_on && attr_ok_low && !in_hole) |=>
    !mem_select_b)
    else $error("enabled low region not selected");

  AST_MID_ON: assert property (@(posedge clock) // [R3]
    disable iff (!rst_b)
    s_take ##0 (mid_ok && below_tom && !in_hole) |=> !mem_select_b)
    else $error("memory below top not selected");

  AST_BIOS_ON: assert property (@(posedge clock) // [R5]
    disable iff (!rst_b)
    s_take ##0 (is_bios && bios_ok && !in_hole) |=> !mem_select_b)
    else $error("enabled BIOS portion not selected");

  AST_BIOS_WR: assert property (@(posedge clock) // [R2]
    disable iff (!rst_b) is_bios && wr_r && !bios_attr[1] |=> mem_select_b)
    else $error("BIOS write selected while read only");

  AST_TRACK: assert property (@(posedge clock) // [R7]
    disable iff (!rst_b)
    window0_select_path_enable |=> (window0_hit == !mem_select_b))
    else $error("window hit differs from select");

  AST_VLD_NO_HIT: assert property (@(posedge clock) // [R8]
    disable iff (!rst_b) s_idle |=> !window0_hit)
    else $error("hit without address phase");

  AST_DEN_OFF: assert property (@(posedge clock) // [R6]
    disable iff (!rst_b)
    window0_select_path_enable && !select_decode_enable |=> devsel_b)
    else $error("DEVSEL while decoder off");

endmodule

// ==== pwcs_master.sv ====
`timescale 1ns/1ps
module pwcs_master
(
  input wire logic clock,
  output logic addr_valid,
  output logic [31:0] pci_addr,
  output logic pci_write
);
  initial
  begin
    addr_valid = 1'b0;
    pci_addr = 32'hFFFF_FFFF;
    pci_write = 1'b0;
  end
  task automatic issue(input logic [31:0] a, input logic w);
    @(posedge clock);
    #2;
    addr_valid = 1'b1;
    pci_addr = a;
    pci_write = w;
    @(posedge clock);
    #2;
    addr_valid = 1'b0;
    // Released bus must not show a stale address
    pci_addr = ~a;
  endtask
endmodule

// ==== pwcs_window0_decode_test.sv ====
`timescale 1ns/1ps
module pwcs_window0_decode_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic av, wr, ms_b, hit, dv_b, sgl, dm;
  logic [31:0] ad;
  logic [7:0] tom = 8'h04, ctl = 8'hFF;
  logic [15:0] ht = 16'h0040, hb = 16'h0030;
  logic [1:0] bios = 2'h3, attr = 2'h3;
  logic [11:0] base = 12'h005, mask = 12'h000;
  logic den = 1'b1, wen = 1'b0, sg = 1'b1, path = 1'b1;
  int n_mismatch = 0;
  int checks_done = 0;
  always #12.5 clock = ~clock;
  pwcs_master m (.clock(clock), .addr_valid(av), .pci_addr(ad), .pci_write(wr));
  pwcs_window0_decode dut (.clock(clock), .rst_b(rst_b), .addr_valid(av),
    .pci_addr(ad), .pci_write(wr), .select_top_of_memory(tom),
    .select_hole_top(ht), .select_hole_bottom(hb), .bios_region_enable_1(bios),
    .bios_region_enable_2(bios), .bios_region_enable_3(bios),
    .select_decode_enable(den), .select_decode_control(ctl),
    .low_region_attr(attr), .window0_base_reg(base), .window0_size_mask(mask),
    .window0_enable(wen), .sg_translate_bit(sg),
    .window0_select_path_enable(path), .mem_select_b(ms_b),
    .window0_hit(hit), .devsel_b(dv_b), .sg_lookup(sgl), .direct_map(dm));
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t outputs %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic probe(input logic [31:0] a, input logic w, h, s);
    m.issue(a, w);
    @(posedge clock);
    #2;
    check({hit, dv_b, sgl, dm, ms_b}, {h, ~h, h & sg, h & ~sg, ~s});
  endtask
  task automatic t_path_on;
    probe(32'h0020_0000, 1'b0, 1'b1, 1'b1);
    probe(32'h000A_0000, 1'b0, 1'b0, 1'b0);
    probe(32'h000B_FFFF, 1'b1, 1'b0, 1'b0);
    probe(32'h007F_FFFC, 1'b0, 1'b1, 1'b1);
    probe(32'h0080_0000, 1'b0, 1'b0, 1'b0);
    probe(32'h0035_0000, 1'b0, 1'b0, 1'b0);
    probe(32'h0040_0000, 1'b0, 1'b1, 1'b1);
    sg = 1'b0;
    probe(32'h0020_0000, 1'b1, 1'b1, 1'b1);
    $display("path on test done");
  endtask
  task automatic t_regions;
    foreach (ctl[i])
      probe({12'h000, i[3:0], 16'h0000}, 1'b0, 1'b1, 1'b1);
    ctl = 8'hFE;
    probe(32'h0000_0000, 1'b0, 1'b0, 1'b0);
    attr = 2'h1;
    probe(32'h0001_0000, 1'b0, 1'b1, 1'b1);
    probe(32'h0001_0000, 1'b1, 1'b0, 1'b0);
    probe(32'h000E_8000, 1'b0, 1'b1, 1'b1);
    bios = 2'h1;
    probe(32'h000F_8000, 1'b1, 1'b0, 1'b0);
    den = 1'b0;
    probe(32'h0020_0000, 1'b0, 1'b0, 1'b0);
    $display("regions test done");
  endtask
  task automatic t_path_off;
    path = 1'b0;
    wen = 1'b1;
    den = 1'b1;
    // Select is still driven, but the window compares its base only
    check({hit, dv_b, sgl, dm, ms_b}, 5'b01001);
    probe(32'h0050_0000, 1'b0, 1'b1, 1'b1);
    probe(32'h0020_0000, 1'b0, 1'b0, 1'b1);
    $display("path off test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    // Window sized over the whole 8MB select region, mask matching it
    mask = 12'h007;
    repeat (16) @(posedge clock);
    #2;
    rst_b = 1'b1;
    t_path_on();
    t_regions();
    mask = 12'h000;
    t_path_off();
    close_out();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule
